/* File: logic/sabt_cfg.svh */
// Register offsets, field positions, reset values and decode limits
`ifndef SABT_CFG_SVH
`define SABT_CFG_SVH

// Address map inside the slave window
`define SABT_EXT_SEL_BIT 12
`define SABT_OFF_TIMING 12'h000
`define SABT_OFF_STATUS 12'h004

// Field positions of the area timing register
`define SABT_WW_MSB 18
`define SABT_WW_LSB 16
`define SABT_SETUP_MSB 12
`define SABT_SETUP_LSB 11
`define SABT_RW_MSB 10
`define SABT_RW_LSB 7
`define SABT_MASK_BIT 6
`define SABT_HOLD_MSB 1
`define SABT_HOLD_LSB 0

// Reset value and writable bits
`define SABT_TIMING_RST 32'h0000_0500
`define SABT_TIMING_WMASK 32'h0007_1fc3

// Status bits
`define SABT_ST_BUSY_BIT 0
`define SABT_ST_STRETCH_BIT 1

`endif

/* File: logic/sabt_pkg.sv */
// Types and wait-count decoding for the area bus timing controller
package sabt_pkg;

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } sabt_state_t;

  // Timing fields as one carrier
  typedef struct packed {
    logic external_wait_mask;
    logic [1:0] hold_delay;
    logic [2:0] write_wait;
    logic [1:0] setup_delay;
    logic [3:0] read_wait;
  } sabt_timing_t;

  // Read-wait code to cycle count; prohibited codes clamp to the longest
  function automatic logic [7:0] sabt_rd_wait(input logic [3:0] code);
    case (code)
      4'h7: sabt_rd_wait = 8'h08;
      4'h8: sabt_rd_wait = 8'h0a;
      4'h9: sabt_rd_wait = 8'h0c;
      4'ha: sabt_rd_wait = 8'h0e;
      4'hb: sabt_rd_wait = 8'h12;
      4'hc: sabt_rd_wait = 8'h18;
      4'hd, 4'he, 4'hf: sabt_rd_wait = 8'h18;
      default: sabt_rd_wait = {4'h0, code};
    endcase
  endfunction : sabt_rd_wait

  // Write-wait code to cycle count, zero falls back to the read setting
  function automatic logic [7:0] sabt_wr_wait(input logic [2:0] ww, input logic [3:0] rw);
    if (ww == 3'h0) begin
      sabt_wr_wait = sabt_rd_wait(rw);
    end else begin
      sabt_wr_wait = {5'h00, ww - 3'h1};
    end
  endfunction : sabt_wr_wait

endpackage : sabt_pkg

/* File: logic/sabt_phase_ctr.sv */
// Loadable down counter that times each access phase
`timescale 1ns/1ps
module sabt_phase_ctr #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire logic [CW-1:0] load_val,
  // Status
  output logic cnt_zero
);

  logic [CW-1:0] cnt_q; // Remaining cycles of the phase

  // Load wins, otherwise count down and stop at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Zero flag straight from the count
  assign cnt_zero = (cnt_q == '0);

endmodule : sabt_phase_ctr

/* File: logic/sabt_area_ctrl.sv */
// AHB-Lite slave and external area access sequencer with programmable timing
//
// Functional notes
// - Mask bit clear honours external wait, set ignores
// - Mask applies even with zero wait cycles
// - Reserved timing bits read zero, write zero
// - Hold field gives 0.5 to 3.5 cycles
// - Write-wait field bits 18 to 16
// - Write-wait zero reuses read-wait count
// - Write-wait codes one to seven mean code minus one
// - Setup field bits 12 and 11
// - Setup codes give 0.5 to 3.5 cycles
// - Read-wait codes decode to 0..6,8,10,12,14,18,24
// - Mask is bit 6, resets to zero
`timescale 1ns/1ps
`include "sabt_cfg.svh"
module sabt_area_ctrl #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External memory side
  output logic [AW-1:0] mem_addr,
  output logic area_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [DW-1:0] mem_data_o,
  output logic mem_data_oe,
  input wire logic [DW-1:0] mem_data_i,
  input wire logic ext_wait_n
);
  import sabt_pkg::*;

  sabt_state_t state_q; // Access sequencer state
  sabt_timing_t tim_q; // Timing latched at access start
  sabt_timing_t tim_cur; // Timing fields of the live register
  logic [31:0] timing_q; // Area timing register
  logic stretch_q; // Last access was stretched by external wait
  logic wr_q; // Current external access is a write
  logic [7:0] wait_q; // Strobe wait cycles of the current access
  logic [DW-1:0] rdata_q; // Data caught at the end of the strobe
  logic reg_wr_pend_q; // Register write waiting for its data phase
  logic [AW-1:0] reg_addr_q; // Register offset of that write
  logic [AW-1:0] ext_addr_q; // External address held from address phase
  logic ext_wr_req_q; // Direction held from address phase
  logic accept; // Address phase taken this cycle
  logic ext_hit; // Address phase targets the external area
  logic stb_lv; // Strobe level before half-cycle placement
  logic ld; // Phase counter load
  logic [7:0] ld_val; // Phase counter load value
  logic cnt_zero; // Phase counter expired
  logic wait_honoured; // External wait stretches this cycle
  logic [31:0] wr_merge; // Masked write data for the timing register
  logic [31:0] reg_rdata; // Register read mux

  assign accept = hsel && htrans[1] && hready;
  assign ext_hit = haddr[`SABT_EXT_SEL_BIT];
  assign stb_lv = (state_q == ST_STROBE);
  assign wr_merge = hwdata & `SABT_TIMING_WMASK;

  // Unpack fields from the live register
  always_comb begin
    tim_cur.external_wait_mask = timing_q[`SABT_MASK_BIT];
    tim_cur.hold_delay = timing_q[`SABT_HOLD_MSB:`SABT_HOLD_LSB];
    tim_cur.write_wait = timing_q[`SABT_WW_MSB:`SABT_WW_LSB];
    tim_cur.setup_delay = timing_q[`SABT_SETUP_MSB:`SABT_SETUP_LSB];
    tim_cur.read_wait = timing_q[`SABT_RW_MSB:`SABT_RW_LSB];
  end

  // Mask set means the pin is never looked at, whatever the wait count
  assign wait_honoured = !tim_q.external_wait_mask && !ext_wait_n;

  // Register read mux; a write still in its data phase is forwarded
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (haddr[AW-1:0] == `SABT_OFF_TIMING) begin
      if (reg_wr_pend_q && reg_addr_q == `SABT_OFF_TIMING) begin
        reg_rdata = wr_merge;
      end else begin
        reg_rdata = timing_q;
      end
    end else if (haddr[AW-1:0] == `SABT_OFF_STATUS) begin
      reg_rdata[`SABT_ST_BUSY_BIT] = (state_q != ST_IDLE);
      reg_rdata[`SABT_ST_STRETCH_BIT] = stretch_q;
    end
  end

  // Register write data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_wr_pend_q <= 1'b0;
      reg_addr_q <= '0;
    end else begin
      reg_wr_pend_q <= accept && hwrite && !ext_hit;
      if (accept) begin
        reg_addr_q <= haddr[AW-1:0];
      end
    end
  end

  // Area timing register; only writable bits are kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing_q <= `SABT_TIMING_RST;
    end else if (reg_wr_pend_q && reg_addr_q == `SABT_OFF_TIMING) begin
      timing_q <= wr_merge;
    end
  end

  // Read data and bus ready; external accesses stall until hold ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && ext_hit) begin
        hreadyout <= 1'b0;
      end else if (state_q == ST_HOLD && cnt_zero) begin
        hreadyout <= 1'b1;
        hrdata <= wr_q ? 32'h0000_0000 : 32'(rdata_q);
      end else if (accept && !hwrite) begin
        hrdata <= reg_rdata;
      end
    end
  end

  // Address phase of an external access is held for the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_addr_q <= '0;
      ext_wr_req_q <= 1'b0;
    end else if (accept && ext_hit) begin
      ext_addr_q <= haddr[AW-1:0];
      ext_wr_req_q <= hwrite;
    end
  end

  // Phase counter loads: setup-1, wait, then hold on each phase entry
  always_comb begin
    ld = 1'b0;
    ld_val = 8'h00;
    case (state_q)
      ST_START: begin
        ld = 1'b1;
        if (tim_cur.setup_delay == 2'h0) begin
          ld_val = ext_wr_req_q ? sabt_wr_wait(tim_cur.write_wait, tim_cur.read_wait)
                                : sabt_rd_wait(tim_cur.read_wait);
        end else begin
          ld_val = {6'h00, tim_cur.setup_delay - 2'h1};
        end
      end
      ST_SETUP: begin
        ld = cnt_zero;
        ld_val = wait_q;
      end
      ST_STROBE: begin
        ld = cnt_zero && !wait_honoured;
        ld_val = {6'h00, tim_q.hold_delay};
      end
      default: begin
        ld = 1'b0;
        ld_val = 8'h00;
      end
    endcase
  end

  sabt_phase_ctr #(.CW(8)) u_ctr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(ld),
    .load_val(ld_val),
    .cnt_zero(cnt_zero)
  );

  // Sequencer: setup, strobe with waits, hold, then release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && ext_hit) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          state_q <= (tim_cur.setup_delay == 2'h0) ? ST_STROBE : ST_SETUP;
        end
        ST_SETUP: begin
          if (cnt_zero) begin
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (cnt_zero && !wait_honoured) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_zero) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-access latches taken when the address goes out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tim_q <= '0;
      wr_q <= 1'b0;
      wait_q <= 8'h00;
      mem_addr <= '0;
      mem_data_o <= '0;
    end else if (state_q == ST_START) begin
      tim_q <= tim_cur;
      wr_q <= ext_wr_req_q;
      wait_q <= ext_wr_req_q ? sabt_wr_wait(tim_cur.write_wait, tim_cur.read_wait)
                             : sabt_rd_wait(tim_cur.read_wait);
      mem_addr <= ext_addr_q;
      mem_data_o <= DW'(hwdata);
    end
  end

  // Area select and data drive span the whole access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      area_select_n <= 1'b1;
      mem_data_oe <= 1'b0;
    end else if (state_q == ST_START) begin
      area_select_n <= 1'b0;
      mem_data_oe <= ext_wr_req_q;
    end else if (state_q == ST_HOLD && cnt_zero) begin
      area_select_n <= 1'b1;
      mem_data_oe <= 1'b0;
    end
  end

  // Read data caught at the last strobe edge; stretch flag per access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
      stretch_q <= 1'b0;
    end else begin
      if (stb_lv && cnt_zero && !wait_honoured) begin
        rdata_q <= mem_data_i;
      end
      if (stb_lv && cnt_zero && wait_honoured) begin
        stretch_q <= 1'b1;
      end else if (state_q == ST_START) begin
        stretch_q <= 1'b0;
      end
    end
  end

  // Strobes move on the falling edge, giving the half-cycle placement
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      read_strobe_n <= !(stb_lv && !wr_q);
      write_strobe_n <= !(stb_lv && wr_q);
    end
  end

  // Helper counters for the checks below
  logic [7:0] pre_cnt;
  logic [7:0] stb_cnt;
  logic [7:0] post_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= 8'h00;
      stb_cnt <= 8'h00;
      post_cnt <= 8'h00;
    end else begin
      pre_cnt <= (state_q == ST_SETUP) ? pre_cnt + 8'h01 : (stb_lv ? pre_cnt : 8'h00);
      stb_cnt <= stb_lv ? stb_cnt + 8'h01 : 8'h00;
      post_cnt <= (state_q == ST_HOLD) ? post_cnt + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_reserved_zero: assert property ((timing_q & ~`SABT_TIMING_WMASK) == 32'h0)
    else $error("reserved timing bits not zero");
  chk_mask_ignores: assert property (stb_lv && cnt_zero && tim_q.external_wait_mask
    |=> state_q == ST_HOLD)
    else $error("masked external wait still stretched strobe");
  chk_wait_stretch: assert property (stb_lv && cnt_zero && !tim_q.external_wait_mask && !ext_wait_n
    |=> stb_lv && !area_select_n)
    else $error("unmasked external wait did not stretch strobe");
  chk_setup_len: assert property ($rose(stb_lv) |-> pre_cnt == {6'h00, tim_q.setup_delay})
    else $error("setup phase length wrong");
  chk_hold_len: assert property ($rose(area_select_n)
    |-> post_cnt == {6'h00, tim_q.hold_delay} + 8'h01)
    else $error("hold phase length wrong");
  chk_strobe_len: assert property ($fell(stb_lv) && tim_q.external_wait_mask
    |-> stb_cnt == wait_q + 8'h01)
    else $error("strobe width differs from wait count");
  chk_ww_fallback: assert property (state_q == ST_START && ext_wr_req_q
    && tim_cur.write_wait == 3'h0 |=> wait_q == sabt_rd_wait(tim_q.read_wait))
    else $error("write wait did not fall back to read wait");
  chk_ww_code: assert property (state_q == ST_START && ext_wr_req_q
    && tim_cur.write_wait == 3'h7 |=> wait_q == 8'h06)
    else $error("write wait code seven not six cycles");
  chk_rw_code: assert property (state_q == ST_START && !ext_wr_req_q
    && tim_cur.read_wait == 4'hb |=> wait_q == 8'h12)
    else $error("read wait code eleven not eighteen cycles");
  chk_strobe_inside: assert property (!read_strobe_n || !write_strobe_n |-> !area_select_n)
    else $error("strobe active outside area select");

  cov_write_access: cover property ($rose(area_select_n) && wr_q);
  cov_read_access: cover property ($rose(area_select_n) && !wr_q);
  cov_stretched: cover property (stb_lv && cnt_zero && wait_honoured);
  cov_long_setup: cover property ($rose(stb_lv) && tim_q.setup_delay == 2'h3);

endmodule : sabt_area_ctrl

/* File: verif/sabt_mem_model.sv */
// External static memory model facing the area access sequencer
`timescale 1ns/1ps
module sabt_mem_model (
  // Clock
  input wire logic hclk,
  // Memory pins from the controller
  input wire logic area_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [11:0] mem_addr,
  input wire logic [31:0] mem_data_o,
  input wire logic mem_data_oe,
  // Memory pins to the controller
  output logic [31:0] mem_data_i,
  output logic ext_wait_n,
  // Rising edges to hold wait low, set by the bench
  input wire logic [7:0] wait_len
);
  logic [31:0] mem [0:4095]; // Storage, one word per address
  logic [31:0] last_q = 32'h0; // Last word put on the bus
  logic [7:0] cnt = 8'h0; // Rising edges seen with a strobe low
  logic drive; // Memory owns the data lines
  logic stb; // Either strobe active

  assign stb = !read_strobe_n || !write_strobe_n;
  assign drive = !area_select_n && !mem_data_oe;
  // Released lines show the inverse so stale data never looks valid
  assign mem_data_i = drive ? mem[mem_addr] : ~last_q;
  // Wait is asked for while the strobe is low, for wait_len edges only
  assign ext_wait_n = !(stb && cnt < wait_len);

  // Strobe edge counter and last driven word
  always @(posedge hclk) begin
    cnt <= stb ? cnt + 8'h1 : 8'h0;
    if (drive) begin
      last_q <= mem[mem_addr];
    end
  end

  // Write data taken as the write strobe ends
  always @(posedge write_strobe_n) begin
    if (!area_select_n) begin
      mem[mem_addr] <= mem_data_o;
    end
  end
endmodule : sabt_mem_model

/* File: verif/tb_top.sv */
// Self-checking bench for the area bus timing controller
`timescale 1ns/1ps
module tb_top;
  import sabt_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, mem_data_o, mem_data_i;
  logic [11:0] mem_addr;
  logic area_select_n, read_strobe_n, write_strobe_n, mem_data_oe, ext_wait_n;
  logic [7:0] wait_len = 8'h0;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] exp_rd[$]; // Expected read data, oldest first
  logic [31:0] exp_tm[$]; // Expected {write, setup, width, hold} in half cycles
  int rtab[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

  // Clock at 100 MHz
  always #5 hclk = ~hclk;

  sabt_area_ctrl i_sabt_area_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
    .area_select_n(area_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe),
    .mem_data_i(mem_data_i), .ext_wait_n(ext_wait_n));
  sabt_mem_model i_sabt_mem_model (.hclk(hclk), .area_select_n(area_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .mem_addr(mem_addr),
    .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe), .mem_data_i(mem_data_i),
    .ext_wait_n(ext_wait_n), .wait_len(wait_len));

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // One compare task per kind of result
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // Read data of a register or external read
  task automatic cmp_rdata(input logic [31:0] e, input logic [31:0] g);
    cmp("hrdata", e, g);
  endtask : cmp_rdata

  // Packed strobe timing of one external access
  task automatic cmp_timing(input logic [31:0] e, input logic [31:0] g);
    cmp("timing", e, g);
  endtask : cmp_timing

  // Transfer response, OKAY is the only answer
  task automatic cmp_resp(input logic [31:0] e, input logic [31:0] g);
    cmp("hresp", e, g);
  endtask : cmp_resp

  // Single AHB-Lite transfer, waits bounded
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 1000);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 1000);
    cmp_resp(32'h0, {31'h0, hresp});
    if (n >= 1000) begin
      fails++;
      end_of_test();
    end
  endtask : ahb

  // External access with w scheduled waits and x requested extensions
  task automatic ext(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input int w, input int x, input int s, input int h, input logic m);
    wait_len <= 8'(w + x);
    exp_tm.push_back({7'h0, wr, 8'(2 * s + 1), 8'(2 * (w + 1 + (m ? 0 : x))), 8'(2 * h + 1)});
    if (!wr) begin
      exp_rd.push_back(d);
    end
    ahb(wr, a, d);
  endtask : ext

  // Read data watcher: one note per completed read data phase
  logic rd_ph = 0;
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      rd_ph = 0;
      cmp_rdata(exp_rd.size() ? exp_rd.pop_front() : 32'hx, hrdata);
    end
    if (hsel && htrans[1] && hreadyout === 1'b1) begin
      rd_ph = !hwrite;
    end
  end

  // Strobe timing watcher, sampled just after both clock edges
  int su = 0, wd = 0, ho = 0;
  logic act = 0, kind = 0;
  always @(hclk) begin
    #1;
    if (area_select_n === 1'b0) begin
      act = 1;
      if (read_strobe_n === 1'b0 || write_strobe_n === 1'b0) begin
        wd++;
        kind = !write_strobe_n;
      end else if (wd == 0) begin
        su++;
      end else begin
        ho++;
      end
    end else if (act) begin
      cmp_timing(exp_tm.size() ? exp_tm.pop_front() : 32'hx,
          {7'h0, kind, 8'(su), 8'(wd), 8'(ho)});
      act = 0;
      su = 0;
      wd = 0;
      ho = 0;
    end
  end

  // Main sequence
  initial begin
    int s, h, ww, x;
    logic m;
    logic [31:0] cfg, a, d;
    void'($urandom(93));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset value, unmapped offset
    exp_rd.push_back(32'h0000_0500);
    ahb(0, 32'h0, 32'h0);
    ahb(1, 32'h8, 32'hffff_ffff);
    exp_rd.push_back(32'h0);
    ahb(0, 32'h8, 32'h0);
    $display("test reset_and_unmapped done");
    // Every writable bit set, reserved bits written and read as zero
    ahb(1, 32'h0, 32'h0007_1fc3);
    exp_rd.push_back(32'h0007_1fc3);
    ahb(0, 32'h0, 32'h0);
    $display("test reserved_bits done");
    // Read-wait codes 0 to 12, every write-wait code, setup, hold and mask
    for (int i = 0; i < 13; i++) begin
      s = i % 4;
      h = (i / 4) % 4;
      ww = i % 8;
      m = (i % 3 == 1);
      x = 1 + $urandom % 2;
      d = $urandom;
      a = 32'h1000 | ($urandom & 32'hffc);
      cfg = {13'h0, 3'(ww), 3'h0, 2'(s), 4'(i), m, 4'h0, 2'(h)};
      ahb(1, 32'h0, cfg);
      exp_rd.push_back(cfg);
      ahb(0, 32'h0, 32'h0);
      ext(1, a, d, ww == 0 ? rtab[i] : ww - 1, x, s, h, m);
      ext(0, a, d, rtab[i], x, s, h, m);
      // Status: idle, stretch flag set only when the wait was honoured
      exp_rd.push_back({30'h0, !m, 1'b0});
      ahb(0, 32'h4, 32'h0);
    end
    $display("test access_timing done");
    repeat (4) @(posedge hclk);
    if (exp_rd.size() != 0 || exp_tm.size() != 0) begin
      fails++;
    end
    end_of_test();
  end
endmodule : tb_top
